// ---- core/ccs_clock_ctrl.sv ----
// Implementation choices: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module ccs_clock_ctrl (
  input wire logic pclk, // APB clock
  input wire logic presetn, // External reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic main_osc_input, // Main oscillator level
  input wire logic onchip_osc_tick, // On-chip oscillator tick
  input wire logic stop_wake, // Wake from stop mode
  output logic main_osc_output, // Main oscillator drive
  output logic cpu_tick, // CPU clock enable pulse
  output logic periph_tick, // Peripheral clock pulse
  output logic osc_stop_reset, // Internal reset pulse
  output logic cpu_halted, // Stop mode active
  output logic rc_osc_select, // 1 = RC, 0 = ceramic
  output logic [1:0] processor_mode, // Processor mode bits
  output logic timer1_load, // Timer preload strobe
  output logic [7:0] timer1_value, // Timer 1 preload value
  output logic [7:0] prescaler1_value // Prescaler 1 preload value
);
  // ****************************************
  // State
  // ****************************************
  logic [7:0] cpu_clock_mode_reg;
  logic [7:0] cpu_clock_mode_next;
  logic mode_lock_reg;
  logic [1:0] onchip_ratio_reg;
  logic detect_active_reg;
  logic stop_rst_en_reg;
  logic stop_status_reg;
  logic stab_wait_reg;
  logic main_prev_reg;
  logic halted_reg;
  logic int_rst_reg;
  ccs_pkg::ccs_src_t src_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic cpu_tick_reg;
  logic periph_tick_reg;
  logic main_out_reg;
  logic timer1_load_reg;
  logic [7:0] timer1_value_reg;
  logic [7:0] prescaler1_value_reg;

  logic addr_ok;
  logic commit;
  logic wr_mode;
  logic wr_set;
  logic wr_clr;
  logic wr_ratio;
  logic wr_misc;
  logic wr_stop;
  logic mode_written;
  logic main_running;
  logic onchip_running;
  logic main_tick;
  logic onchip_tick;
  logic src_tick;
  logic enter_onchip;
  logic stop_event;
  logic [31:0] read_value;
  logic [1:0] div_sel_reg;
  logic [1:0] div_sel_next;

  ccs_div_if div_bus ();

  // ****************************************
  // APB slave
  // ****************************************
  always_comb begin
    case (paddr)
      ccs_pkg::ADDR_CPU_MODE, ccs_pkg::ADDR_ONCHIP_RATIO, ccs_pkg::ADDR_MISC_STOP,
      ccs_pkg::ADDR_MODE_SET, ccs_pkg::ADDR_MODE_CLR, ccs_pkg::ADDR_STOP_CMD,
      ccs_pkg::ADDR_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  assign commit = psel & penable & pready_reg & pwrite & addr_ok;
  assign wr_mode = commit & (paddr == ccs_pkg::ADDR_CPU_MODE);
  assign wr_set = commit & (paddr == ccs_pkg::ADDR_MODE_SET);
  assign wr_clr = commit & (paddr == ccs_pkg::ADDR_MODE_CLR);
  assign wr_ratio = commit & (paddr == ccs_pkg::ADDR_ONCHIP_RATIO);
  assign wr_misc = commit & (paddr == ccs_pkg::ADDR_MISC_STOP);
  assign wr_stop = commit & (paddr == ccs_pkg::ADDR_STOP_CMD) & pwdata[0];
  assign mode_written = wr_mode | wr_set | wr_clr;

  always_comb begin
    case (paddr)
      ccs_pkg::ADDR_CPU_MODE: read_value = {24'h00_0000, cpu_clock_mode_reg};
      ccs_pkg::ADDR_ONCHIP_RATIO: read_value = {30'h0000_0000, onchip_ratio_reg};
      ccs_pkg::ADDR_MISC_STOP: read_value = {28'h000_0000, stab_wait_reg, stop_status_reg,
                                             stop_rst_en_reg, detect_active_reg};
      ccs_pkg::ADDR_STATUS: read_value = {29'h0000_0000, mode_lock_reg, halted_reg,
                                          src_reg == ccs_pkg::CCS_SRC_ONCHIP};
      default: read_value = ccs_pkg::READ_ZERO;
    endcase
  end

  // Read data is zero outside the answer cycle, so no stale word lingers on the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= ccs_pkg::READ_ZERO;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & ~addr_ok;
      if (psel && penable && !pready_reg && !pwrite) begin
        prdata_reg <= read_value;
      end else begin
        prdata_reg <= ccs_pkg::READ_ZERO;
      end
    end
  end

  // ****************************************
  // CPU mode register
  // ****************************************
  always_comb begin
    cpu_clock_mode_next = cpu_clock_mode_reg;
    if (wr_mode) begin
      cpu_clock_mode_next = pwdata[7:0];
    end else if (wr_set) begin
      cpu_clock_mode_next = cpu_clock_mode_reg | pwdata[7:0];
    end else if (wr_clr) begin
      cpu_clock_mode_next = cpu_clock_mode_reg & ~pwdata[7:0];
    end
    if (mode_lock_reg) begin
      cpu_clock_mode_next = (cpu_clock_mode_next & ~ccs_pkg::LOCKED_BITS) |
                            (cpu_clock_mode_reg & ccs_pkg::LOCKED_BITS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clock_mode_reg <= ccs_pkg::CPU_MODE_RESET;
    end else if (int_rst_reg) begin
      cpu_clock_mode_reg <= ccs_pkg::CPU_MODE_RESET;
    end else begin
      cpu_clock_mode_reg <= cpu_clock_mode_next;
    end
  end

  // Any set or clear counts as the one allowed write, so it locks too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_lock_reg <= 1'b0;
    end else if (int_rst_reg) begin
      mode_lock_reg <= 1'b0;
    end else if (mode_written) begin
      mode_lock_reg <= 1'b1;
    end
  end

  // ****************************************
  // Clock source and on-chip ratio
  // ****************************************
  assign div_sel_reg = cpu_clock_mode_reg[ccs_pkg::DIV_HI:ccs_pkg::DIV_LO];
  assign div_sel_next = cpu_clock_mode_next[ccs_pkg::DIV_HI:ccs_pkg::DIV_LO];

  // Only the step into on-chip mode forces /8; a later ratio write still wins
  assign enter_onchip = (div_sel_next == ccs_pkg::DIV_ONCHIP) &&
                        (div_sel_reg != ccs_pkg::DIV_ONCHIP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg <= ccs_pkg::CCS_SRC_ONCHIP;
    end else if (int_rst_reg) begin
      src_reg <= ccs_pkg::CCS_SRC_ONCHIP;
    end else begin
      case (div_sel_next)
        ccs_pkg::DIV_ONCHIP: src_reg <= ccs_pkg::CCS_SRC_ONCHIP;
        default: src_reg <= ccs_pkg::CCS_SRC_MAIN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      onchip_ratio_reg <= ccs_pkg::RATIO_RESET;
    end else if (int_rst_reg) begin
      onchip_ratio_reg <= ccs_pkg::RATIO_RESET;
    end else if (enter_onchip) begin
      onchip_ratio_reg <= ccs_pkg::RATIO_RESET;
    end else if (wr_ratio) begin
      onchip_ratio_reg <= pwdata[1:0];
    end
  end

  // ****************************************
  // Oscillator ticks and CPU divider
  // ****************************************
  // Run bits are active low: 1 stops the oscillator
  assign main_running = ~cpu_clock_mode_reg[ccs_pkg::MAIN_RUN_BIT] & ~halted_reg;
  assign onchip_running = ~cpu_clock_mode_reg[ccs_pkg::ONCHIP_RUN_BIT];
  assign main_tick = main_osc_input & ~main_prev_reg & main_running;
  assign onchip_tick = onchip_osc_tick & onchip_running;
  assign src_tick = (src_reg == ccs_pkg::CCS_SRC_ONCHIP) ? onchip_tick : main_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_prev_reg <= 1'b0;
    end else begin
      main_prev_reg <= main_osc_input;
    end
  end

  assign div_bus.src_tick = src_tick;
  // Double speed is trusted to be chosen only with ceramic
  assign div_bus.last = (src_reg == ccs_pkg::CCS_SRC_ONCHIP) ?
                        ccs_pkg::onchip_last(onchip_ratio_reg) :
                        ccs_pkg::main_last(div_sel_reg);

  ccs_cpu_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .dv(div_bus)
  );

  // Peripheral tick follows the source, never the CPU ratio
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_tick_reg <= 1'b0;
      periph_tick_reg <= 1'b0;
      main_out_reg <= 1'b0;
    end else begin
      cpu_tick_reg <= div_bus.tick_out & ~halted_reg;
      periph_tick_reg <= src_tick;
      main_out_reg <= main_running & ~main_osc_input;
    end
  end

  // ****************************************
  // Stop mode
  // ****************************************
  // Wake beats a same-cycle stop command, so the core cannot be left stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted_reg <= 1'b0;
    end else if (int_rst_reg || stop_wake) begin
      halted_reg <= 1'b0;
    end else if (wr_stop) begin
      halted_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer1_load_reg <= 1'b0;
      timer1_value_reg <= ccs_pkg::TIMER1_PRELOAD;
      prescaler1_value_reg <= ccs_pkg::PRESCALER1_PRELOAD;
    end else begin
      // Wait bit set leaves the timers to software
      timer1_load_reg <= wr_stop & ~stab_wait_reg;
      timer1_value_reg <= ccs_pkg::TIMER1_PRELOAD;
      prescaler1_value_reg <= ccs_pkg::PRESCALER1_PRELOAD;
    end
  end

  // ****************************************
  // Oscillation stop detection
  // ****************************************
  // Counts on-chip ticks, so it is blind while that oscillator is stopped
  ccs_osc_stop_det u_det (
    .pclk(pclk),
    .presetn(presetn),
    .enable(detect_active_reg & onchip_running),
    .main_tick(main_tick),
    .onchip_tick(onchip_tick),
    .stop_event(stop_event)
  );

  // Registered, so the internal reset lands one edge after the event and lasts one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_rst_reg <= 1'b0;
    end else begin
      int_rst_reg <= stop_event & stop_rst_en_reg;
    end
  end

  // Active bit and status are kept across the internal reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_active_reg <= 1'b0;
    end else if (wr_misc) begin
      detect_active_reg <= pwdata[ccs_pkg::MISC_ACTIVE];
    end
  end

  // Clearing the enable makes one lost resonator cost one internal reset, not a storm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_rst_en_reg <= 1'b0;
      stab_wait_reg <= 1'b0;
    end else if (int_rst_reg) begin
      stop_rst_en_reg <= 1'b0;
      stab_wait_reg <= 1'b0;
    end else if (wr_misc) begin
      stop_rst_en_reg <= pwdata[ccs_pkg::MISC_RST_EN];
      stab_wait_reg <= pwdata[ccs_pkg::MISC_STAB_WAIT];
    end
  end

  // Set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_status_reg <= 1'b0;
    end else if (stop_event) begin
      stop_status_reg <= 1'b1;
    end else if (wr_misc && !pwdata[ccs_pkg::MISC_ACTIVE]) begin
      stop_status_reg <= 1'b0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every pin below is a bare register, so no decode glitch reaches the outside
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign main_osc_output = main_out_reg;
  assign cpu_tick = cpu_tick_reg;
  assign periph_tick = periph_tick_reg;
  assign osc_stop_reset = int_rst_reg;
  assign cpu_halted = halted_reg;
  assign rc_osc_select = cpu_clock_mode_reg[ccs_pkg::OSC_MODE_BIT];
  assign processor_mode = cpu_clock_mode_reg[1:0];
  assign timer1_load = timer1_load_reg;
  assign timer1_value = timer1_value_reg;
  assign prescaler1_value = prescaler1_value_reg;
endmodule
`default_nettype wire

// ---- core/ccs_cpu_divider.sv ----
`timescale 1ns/10ps
`default_nettype none
module ccs_cpu_divider (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  ccs_div_if.div dv // Source tick and ratio
);
  logic [6:0] cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 7'h00;
      dv.tick_out <= 1'b0;
    end else if (dv.src_tick) begin
      // Compare with >= so a smaller ratio takes effect at once
      if (cnt_reg >= dv.last) begin
        cnt_reg <= 7'h00;
        dv.tick_out <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 7'h01;
        dv.tick_out <= 1'b0;
      end
    end else begin
      dv.tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- core/ccs_div_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface ccs_div_if;
  logic src_tick;
  logic [6:0] last;
  logic tick_out;
  modport ctrl (output src_tick, output last, input tick_out);
  modport div (input src_tick, input last, output tick_out);
endinterface
`default_nettype wire

// ---- core/ccs_osc_stop_det.sv ----
`timescale 1ns/10ps
`default_nettype none
module ccs_osc_stop_det (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic enable, // Detector armed
  input wire logic main_tick, // Main oscillator edge
  input wire logic onchip_tick, // On-chip oscillator tick
  output logic stop_event // One pulse per stop seen
);
  logic [7:0] gap_reg;

  // On-chip ticks since the last main edge; a long gap means a dead resonator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_reg <= 8'h00;
      stop_event <= 1'b0;
    end else if (!enable || main_tick) begin
      gap_reg <= 8'h00;
      stop_event <= 1'b0;
    end else if (onchip_tick && gap_reg != ccs_pkg::STOP_LIMIT) begin
      gap_reg <= gap_reg + 8'h01;
      stop_event <= (gap_reg + 8'h01) == ccs_pkg::STOP_LIMIT;
    end else begin
      stop_event <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- core/ccs_pkg.sv ----
package ccs_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CPU_MODE = 8'h00;
  localparam logic [7:0] ADDR_ONCHIP_RATIO = 8'h04;
  localparam logic [7:0] ADDR_MISC_STOP = 8'h08;
  localparam logic [7:0] ADDR_MODE_SET = 8'h0C;
  localparam logic [7:0] ADDR_MODE_CLR = 8'h10;
  localparam logic [7:0] ADDR_STOP_CMD = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int DIV_HI = 7;
  localparam int DIV_LO = 6;
  localparam int OSC_MODE_BIT = 5;
  localparam int MAIN_RUN_BIT = 4;
  localparam int ONCHIP_RUN_BIT = 3;
  localparam logic [7:0] LOCKED_BITS = 8'h23;
  localparam logic [7:0] CPU_MODE_RESET = 8'h80;
  localparam logic [1:0] DIV_HIGH = 2'h0;
  localparam logic [1:0] DIV_MIDDLE = 2'h1;
  localparam logic [1:0] DIV_ONCHIP = 2'h2;
  localparam logic [1:0] DIV_DOUBLE = 2'h3;
  localparam logic [1:0] RATIO_RESET = 2'h2;
  localparam int MISC_ACTIVE = 0;
  localparam int MISC_RST_EN = 1;
  localparam int MISC_STATUS = 2;
  localparam int MISC_STAB_WAIT = 3;
  localparam logic [7:0] TIMER1_PRELOAD = 8'h01;
  localparam logic [7:0] PRESCALER1_PRELOAD = 8'hFF;
  localparam logic [7:0] STOP_LIMIT = 8'h20;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef enum logic {CCS_SRC_ONCHIP, CCS_SRC_MAIN} ccs_src_t;

  // Terminal count of the CPU divider for a main oscillator setting
  function automatic logic [6:0] main_last(input logic [1:0] sel);
    case (sel)
      DIV_DOUBLE: main_last = 7'h00;
      DIV_HIGH: main_last = 7'h01;
      default: main_last = 7'h07;
    endcase
  endfunction

  // Terminal count of the CPU divider for an on-chip ratio
  function automatic logic [6:0] onchip_last(input logic [1:0] ratio);
    case (ratio)
      2'h0: onchip_last = 7'h00;
      2'h1: onchip_last = 7'h01;
      2'h2: onchip_last = 7'h07;
      default: onchip_last = 7'h7F;
    endcase
  endfunction
endpackage

// ---- verification/ccs_clock_ctrl_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module ccs_clock_ctrl_chk (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic cpu_tick, // CPU tick
  input wire logic periph_tick, // Peripheral tick
  input wire logic osc_stop_reset, // Internal reset
  input wire logic cpu_halted, // Stop mode
  input wire logic rc_osc_select, // Mode bit 5
  input wire logic [1:0] processor_mode, // Mode bits 1:0
  input wire logic timer1_load, // Preload strobe
  input wire logic [7:0] timer1_value, // Timer 1 preload
  input wire logic [7:0] prescaler1_value // Prescaler 1 preload
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_ok;
  logic mode_wr;
  logic lock_reg;
  assign wr_ok = psel && penable && pready && pwrite;
  assign mode_wr = wr_ok && (paddr == ccs_pkg::ADDR_CPU_MODE || paddr == ccs_pkg::ADDR_MODE_SET ||
                             paddr == ccs_pkg::ADDR_MODE_CLR);
  // Internal reset reopens the one write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lock_reg <= 1'b0;
    else if (osc_stop_reset) lock_reg <= 1'b0;
    else if (mode_wr) lock_reg <= 1'b1;
  end
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  AST_READY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_LOCK_HOLD: assert property (
    lock_reg && mode_wr && !osc_stop_reset |=> $stable({rc_osc_select, processor_mode}))
    else $error("locked mode bits changed");
  AST_TICK_PAIR: assert property (cpu_tick |-> periph_tick || $past(periph_tick))
    else $error("cpu tick without source tick");
  AST_STOP_PULSE: assert property (osc_stop_reset |=> !osc_stop_reset)
    else $error("internal reset too long");
  AST_PRELOAD: assert property (
    timer1_value == ccs_pkg::TIMER1_PRELOAD && prescaler1_value == ccs_pkg::PRESCALER1_PRELOAD)
    else $error("preload value wrong");
  AST_LOAD_HALT: assert property (timer1_load |-> ##[0:1] cpu_halted)
    else $error("preload outside stop");
  AST_HALT_CMD: assert property (
    wr_ok && paddr == ccs_pkg::ADDR_STOP_CMD && pwdata[0] |=> cpu_halted)
    else $error("stop command ignored");
  cover property (osc_stop_reset);
  cover property (timer1_load);
  cover property (pslverr);
endmodule
bind ccs_clock_ctrl ccs_clock_ctrl_chk u_ccs_clock_ctrl_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .cpu_tick(cpu_tick), .periph_tick(periph_tick), .osc_stop_reset(osc_stop_reset), .cpu_halted(cpu_halted),
  .rc_osc_select(rc_osc_select), .processor_mode(processor_mode), .timer1_load(timer1_load),
  .timer1_value(timer1_value), .prescaler1_value(prescaler1_value));
`default_nettype wire

// ---- verification/ccs_clock_ctrl_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module ccs_clock_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, onchip_osc_tick, stop_wake, xtal_run, osc_en;
  logic pready, pslverr, main_osc_input, main_osc_output, cpu_tick, periph_tick, osc_stop_reset;
  logic cpu_halted, rc_osc_select, timer1_load, rerr;
  logic [1:0] processor_mode;
  logic [7:0] paddr, timer1_value, prescaler1_value;
  logic [31:0] pwdata, prdata, rdat;
  int n_mismatch, n_compared, n_cpu, n_per, n_srst, n_load, n_xo, ocnt;
  int dv[4] = '{1, 2, 8, 128};
  always #12.5 pclk = ~pclk;
  ccs_clock_ctrl u_ccs_clock_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_osc_input(main_osc_input), .onchip_osc_tick(onchip_osc_tick), .stop_wake(stop_wake),
    .main_osc_output(main_osc_output), .cpu_tick(cpu_tick), .periph_tick(periph_tick),
    .osc_stop_reset(osc_stop_reset), .cpu_halted(cpu_halted), .rc_osc_select(rc_osc_select),
    .processor_mode(processor_mode), .timer1_load(timer1_load), .timer1_value(timer1_value),
    .prescaler1_value(prescaler1_value));
  ccs_xtal_model u_ccs_xtal_model (.pclk(pclk), .run(xtal_run), .osc_out(main_osc_input));
  // On-chip oscillator: one tick every four cycles
  always @(posedge pclk) begin
    ocnt <= (ocnt == 3) ? 0 : ocnt + 1;
    onchip_osc_tick <= osc_en && ocnt == 0;
    if (cpu_tick) n_cpu++;
    if (periph_tick) n_per++;
    if (osc_stop_reset) n_srst++;
    if (timer1_load) n_load++;
    if (main_osc_output) n_xo++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask
  task automatic rst;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // Tolerance of one division covers the divider phase at the window edges
  task automatic meas(input int div, input int per);
    int c0, p0, dc, dp;
    repeat (600) @(posedge pclk);
    c0 = n_cpu;
    p0 = n_per;
    repeat (4000) @(posedge pclk);
    dc = n_cpu - c0;
    dp = n_per - p0;
    chk(32'(dc * div <= dp + div && dc * div + div >= dp && dp > 0), 32'h0000_0001);
    if (per > 0) chk(32'(dp >= per - 2 && dp <= per + 2), 32'h0000_0001);
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
  initial begin
    pclk = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; stop_wake = 0;
    onchip_osc_tick = 0; xtal_run = 1; osc_en = 1; ocnt = 0;
    rst();
    rd(ccs_pkg::ADDR_CPU_MODE, 32'h0000_0080);
    rd(ccs_pkg::ADDR_ONCHIP_RATIO, 32'h0000_0002);
    rd(ccs_pkg::ADDR_STATUS, 32'h0000_0001);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(rerr, 1'b1);
    meas(8, 1000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(ccs_pkg::ADDR_ONCHIP_RATIO, 32'(i));
      meas(dv[i], 1000);
    end
    $display("test onchip ratio done");
    wr(ccs_pkg::ADDR_CPU_MODE, 32'h0000_0000);
    n_xo = 0;
    meas(2, 667);
    // Drive inverts the running resonator: high for half of the 4600 measured cycles
    chk(32'(n_xo >= 2290 && n_xo <= 2310), 32'h0000_0001);
    wr(ccs_pkg::ADDR_MODE_SET, 32'h0000_0040);
    meas(8, 0);
    // Undivided only while ceramic is chosen
    wr(ccs_pkg::ADDR_MODE_SET, 32'h0000_00C0);
    meas(1, 0);
    wr(ccs_pkg::ADDR_MODE_CLR, 32'h0000_0040);
    meas(8, 1000);
    wr(ccs_pkg::ADDR_MODE_SET, 32'h0000_0010);
    repeat (8) @(posedge pclk);
    n_xo = 0;
    chk(main_osc_output, 1'b0);
    repeat (12) @(posedge pclk);
    chk(n_xo, 0);
    $display("test source switch done");
    rst();
    wr(ccs_pkg::ADDR_CPU_MODE, 32'h0000_00A3);
    @(posedge pclk);
    chk({rc_osc_select, processor_mode}, 3'h7);
    wr(ccs_pkg::ADDR_CPU_MODE, 32'h0000_0080);
    rd(ccs_pkg::ADDR_CPU_MODE, 32'h0000_00A3);
    for (int k = 0; k < 2; k++) begin
      rst();
      wr(k ? ccs_pkg::ADDR_MODE_CLR : ccs_pkg::ADDR_MODE_SET, 32'h0000_0004);
      wr(ccs_pkg::ADDR_CPU_MODE, 32'h0000_00A3);
      rd(ccs_pkg::ADDR_CPU_MODE, 32'h0000_0080);
    end
    rst();
    wr(ccs_pkg::ADDR_CPU_MODE, 32'h0000_0090);
    rd(ccs_pkg::ADDR_CPU_MODE, 32'h0000_0090);
    $display("test lock done");
    rst();
    // CPU stays on the on-chip source while the resonator dies
    wr(ccs_pkg::ADDR_MISC_STOP, 32'h0000_0001);
    repeat (400) @(posedge pclk);
    rd(ccs_pkg::ADDR_MISC_STOP, 32'h0000_0001);
    n_srst = 0;
    xtal_run <= 1'b0;
    repeat (400) @(posedge pclk);
    rd(ccs_pkg::ADDR_MISC_STOP, 32'h0000_0005);
    chk(n_srst, 0);
    wr(ccs_pkg::ADDR_MISC_STOP, 32'h0000_0000);
    rd(ccs_pkg::ADDR_MISC_STOP, 32'h0000_0000);
    wr(ccs_pkg::ADDR_MISC_STOP, 32'h0000_0003);
    repeat (400) @(posedge pclk);
    chk(n_srst, 1);
    rd(ccs_pkg::ADDR_MISC_STOP, 32'h0000_0005);
    rst();
    xtal_run <= 1'b1;
    rd(ccs_pkg::ADDR_MISC_STOP, 32'h0000_0000);
    $display("test stop detect done");
    // Detector left inactive before stop
    n_load = 0;
    wr(ccs_pkg::ADDR_STOP_CMD, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk({cpu_halted, 8'(n_load)}, 9'h101);
    stop_wake <= 1'b1;
    @(posedge pclk);
    stop_wake <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(cpu_halted, 1'b0);
    wr(ccs_pkg::ADDR_MISC_STOP, 32'h0000_0008);
    wr(ccs_pkg::ADDR_STOP_CMD, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk({cpu_halted, 8'(n_load)}, 9'h101);
    $display("test stop mode done");
    test_done();
  end
endmodule
`default_nettype wire

// ---- verification/ccs_xtal_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module ccs_xtal_model #(
  parameter int HALF = 3
) (
  input wire logic pclk, // Bench clock
  input wire logic run, // Resonator intact
  output logic osc_out // Main oscillator level
);
  int cnt = 0;
  // Free-running from time zero, so it is settled before any switch
  // A broken resonator freezes at its level, like a cut network
  initial osc_out = 1'b0;
  always @(posedge pclk) begin
    if (run) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        osc_out <= !osc_out;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire
